// file: dv/hfc_link_model.sv
// Link side model: feeds received frames and drains the transmit stream.
// Assumes the hfc_ctrl byte handshake, one receive pulse per cycle.
`timescale 1ns/100ps
`default_nettype none
module hfc_link_model (
  input  wire logic            mclk,
  output logic                 rx_frame_start,
  output logic                 rx_byte_valid,
  output logic [7:0]           rx_byte,
  output logic                 rx_frame_end,
  output hfc_pkg::hfc_rx_end_t rx_end_info,
  input  wire logic            tx_valid,
  input  wire logic [7:0]      tx_data,
  input  wire logic            tx_first,
  input  wire logic            tx_last,
  input  wire logic            tx_abort,
  output logic                 tx_ready,
  output logic                 tx_closed,
  output logic                 tx_collision
);
  logic [7:0] rxq[$];
  logic [9:0] txq[$];
  int         aborts = 0;

  // Idle levels at time zero
  initial
  begin
    rx_frame_start = 1'b0;
    rx_byte_valid = 1'b0;
    rx_byte = 8'hA5;
    rx_frame_end = 1'b0;
    rx_end_info = 7'h00;
    tx_ready = 1'b0;
    tx_closed = 1'b0;
    tx_collision = 1'b0;
  end

  // One frame: start pulse, n random bytes, end pulse with status
  task automatic send_frame(input int n, input hfc_pkg::hfc_rx_end_t info);
    logic [7:0] b;
    @(posedge mclk);
    rx_frame_start <= 1'b1;
    for (int i = 0; i < n; i++)
    begin
      b = 8'($urandom);
      rxq.push_back(b);
      @(posedge mclk);
      rx_frame_start <= 1'b0;
      rx_byte_valid <= 1'b1;
      rx_byte <= b;
    end
    @(posedge mclk);
    rx_frame_start <= 1'b0;
    rx_byte_valid <= 1'b0;
    rx_byte <= ~rx_byte;
    rx_frame_end <= 1'b1;
    rx_end_info <= info;
    @(posedge mclk);
    rx_frame_end <= 1'b0;
    rx_end_info <= ~info;
  endtask

  // One-cycle bus collision pulse
  task automatic collide();
    @(posedge mclk);
    tx_collision <= 1'b1;
    @(posedge mclk);
    tx_collision <= 1'b0;
  endtask

  // Take transmit bytes with random stalls, flag closing after last
  always @(posedge mclk)
  begin
    tx_ready <= ($urandom % 4) != 0;
    tx_closed <= tx_valid & tx_ready & tx_last;
    if (tx_valid && tx_ready)
      txq.push_back({tx_first, tx_last, tx_data});
    if (tx_abort)
      aborts++;
  end
endmodule
`default_nettype wire

// file: dv/tb.sv
// Bench for hfc_ctrl: APB host tasks, queue model, link partner.
// Assumes a zero-wait APB slave and hfc_link_model on the link side.
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic                 mclk = 1'b0;
  logic                 resetn = 1'b0;
  logic                 psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic                 pready, pslverr, err_q;
  logic [7:0]           paddr = 8'h00, rx_byte, tx_data;
  logic [31:0]          pwdata = 32'h0, prdata, v;
  logic                 rx_frame_start, rx_byte_valid, rx_frame_end, tx_valid, tx_first, tx_last;
  logic                 tx_share_flags, tx_abort, tx_ready, tx_closed, tx_collision;
  hfc_pkg::hfc_rx_end_t rx_end_info;
  int                   num_errors = 0, cmp_count = 0, a0;
  logic [7:0]           expq[$];
  logic [2:0]           md[3] = '{hfc_pkg::MODE_NONAUTO2, hfc_pkg::MODE_TRANS0, hfc_pkg::MODE_TRANS1};

  hfc_ctrl dut (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_frame_start(rx_frame_start), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
    .rx_frame_end(rx_frame_end), .rx_end_info(rx_end_info), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_first(tx_first), .tx_last(tx_last), .tx_share_flags(tx_share_flags), .tx_abort(tx_abort),
    .tx_ready(tx_ready), .tx_closed(tx_closed), .tx_collision(tx_collision));
  hfc_link_model link (.mclk(mclk), .rx_frame_start(rx_frame_start), .rx_byte_valid(rx_byte_valid),
    .rx_byte(rx_byte), .rx_frame_end(rx_frame_end), .rx_end_info(rx_end_info), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_first(tx_first), .tx_last(tx_last), .tx_abort(tx_abort),
    .tx_ready(tx_ready), .tx_closed(tx_closed), .tx_collision(tx_collision));

  // Clock
  always #20 mclk = ~mclk;

  task automatic final_report();
    if (num_errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("wrong value %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  task automatic chk_byte(input string nm, input logic [9:0] e, input logic [9:0] g);
    chk(nm, 32'(e), 32'(g));
  endtask

  // APB transfer: setup, access until pready, result left in v
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
      @(posedge mclk);
    while (pready !== 1'b1);
    v = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cmd(input logic [31:0] c);
    apb(1'b1, hfc_pkg::ADDR_CMD, c);
  endtask

  // Read interrupt status until a bit shows, bounded
  task automatic poll(input int b);
    for (int k = 0; k < 60; k++)
    begin
      apb(1'b0, hfc_pkg::ADDR_ISR, 32'h0);
      if (v[b] === 1'b1)
        break;
    end
  endtask

  // Receive one frame, read count, then two bytes or, when full, all bytes and status, then release
  task automatic rx_frame(input int n, input bit full, input logic [2:0] m);
    hfc_pkg::hfc_rx_end_t inf;
    logic [7:0]           st;
    inf = 7'($urandom);
    st = {inf.valid, 1'b0, inf.crc_ok, inf.abort, inf.sapi, inf.cr, inf.tei};
    st = st & ((m == hfc_pkg::MODE_TRANS0) ? 8'hF0 : 8'hFF);
    link.send_frame(n, inf);
    poll(hfc_pkg::IRQ_RME);
    chk("isr rme", 32'h1, 32'(v[hfc_pkg::IRQ_RME]));
    apb(1'b0, hfc_pkg::ADDR_CNTL, 32'h0);
    chk("count low", 32'(n + 1), v);
    apb(1'b0, hfc_pkg::ADDR_CNTH, 32'h0);
    chk("count high", 32'h0, v);
    expq = link.rxq;
    link.rxq.delete();
    expq.push_back(st);
    for (int k = 0; k < (full ? n + 2 : 2); k++)
    begin
      apb(1'b0, hfc_pkg::ADDR_FIFO, 32'h0);
      chk("rx byte", 32'(expq[(k > n) ? n : k]), v);
    end
    cmd(32'h1 << hfc_pkg::CMD_RMC);
  endtask

  // Random bytes into the transmit FIFO
  task automatic txw(input int n);
    logic [7:0] b;
    for (int k = 0; k < n; k++)
    begin
      b = 8'($urandom);
      expq.push_back(b);
      apb(1'b1, hfc_pkg::ADDR_FIFO, 32'(b));
    end
  endtask

  // Main sequence
  initial
  begin
    a0 = $urandom(36);
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    apb(1'b0, hfc_pkg::ADDR_ISR, 32'h0);
    chk("isr reset", 32'h0, v);
    foreach (md[i])
    begin
      apb(1'b1, hfc_pkg::ADDR_EXM, 32'(md[i]));
      cmd(32'h1 << hfc_pkg::CMD_RRES);
      rx_frame(3 + i * 5, 1'b0, md[i]);
      rx_frame(20 + i, 1'b1, md[i]);
    end
    link.send_frame(70, 7'h00);
    link.send_frame(2, 7'h00);
    poll(hfc_pkg::IRQ_RFO);
    chk("isr rfo", 32'h1, 32'(v[hfc_pkg::IRQ_RFO]));
    cmd(32'h1 << hfc_pkg::CMD_RRES);
    link.rxq.delete();
    // Block size boundary, overflow, transmitter reset
    txw(32);
    apb(1'b0, hfc_pkg::ADDR_STAT, 32'h0);
    chk("tx_data_overflow at block", 32'h0, 32'(v[hfc_pkg::STAT_TX_DATA_OVERFLOW]));
    txw(1);
    apb(1'b0, hfc_pkg::ADDR_STAT, 32'h0);
    chk("tx_data_overflow past block", 32'h1, 32'(v[hfc_pkg::STAT_TX_DATA_OVERFLOW]));
    a0 = link.aborts;
    cmd(32'h1 << hfc_pkg::CMD_TX_RESET_CMD);
    apb(1'b0, hfc_pkg::ADDR_ISR, 32'h0);
    chk("isr xpr reset", 32'h1, 32'(v[hfc_pkg::IRQ_XPR]));
    chk("abort on reset", 32'h1, 32'(link.aborts > a0));
    // Whole frame with message end
    expq.delete();
    link.txq.delete();
    txw(20);
    cmd((32'h1 << hfc_pkg::CMD_XTF) | (32'h1 << hfc_pkg::CMD_XME));
    apb(1'b0, hfc_pkg::ADDR_STAT, 32'h0);
    chk("xfw locked", 32'h0, 32'(v[hfc_pkg::STAT_XFW]));
    poll(hfc_pkg::IRQ_XPR);
    chk("tx taken", 32'd20, 32'(link.txq.size()));
    foreach (expq[k])
      chk_byte("tx byte", {k == 0, k == 19, expq[k]}, link.txq[k]);
    apb(1'b0, hfc_pkg::ADDR_STAT, 32'h0);
    chk("xfw free", 32'h1, 32'(v[hfc_pkg::STAT_XFW]));
    // Frame without end runs dry
    a0 = link.aborts;
    txw(4);
    cmd(32'h1 << hfc_pkg::CMD_XTF);
    for (int k = 0; k < 300 && link.aborts == a0; k++)
      @(posedge mclk);
    apb(1'b0, hfc_pkg::ADDR_STAT, 32'h0);
    chk("xfw underrun", 32'h0, 32'(v[hfc_pkg::STAT_XFW]));
    apb(1'b0, hfc_pkg::ADDR_ISR, 32'h0);
    chk("isr xdu", 32'h1, 32'(v[hfc_pkg::IRQ_XDU]));
    apb(1'b0, hfc_pkg::ADDR_STAT, 32'h0);
    chk("xfw after read", 32'h1, 32'(v[hfc_pkg::STAT_XFW]));
    // Smaller block applies at the next command; collision past it asks for a repeat
    apb(1'b1, hfc_pkg::ADDR_EXM, 32'h1 << hfc_pkg::EXM_TX_BLOCK_SIZE_SEL);
    apb(1'b0, hfc_pkg::ADDR_EXM, 32'h0);
    chk("tx_block_size_sel d-channel", 32'h1, 32'(v[hfc_pkg::EXM_TX_BLOCK_SIZE_SEL]));
    link.txq.delete();
    txw(30);
    cmd(32'h1 << hfc_pkg::CMD_XTF);
    for (int k = 0; k < 300 && link.txq.size() < 17; k++)
      @(posedge mclk);
    link.collide();
    apb(1'b0, hfc_pkg::ADDR_STAT, 32'h0);
    chk("xfw repeat", 32'h0, 32'(v[hfc_pkg::STAT_XFW]));
    apb(1'b0, hfc_pkg::ADDR_ISR, 32'h0);
    chk("isr xmr", 32'h1, 32'(v[hfc_pkg::IRQ_XMR]));
    // Message end alone: pool ready on free space, shared flags
    txw(3);
    cmd(32'h1 << hfc_pkg::CMD_XME);
    poll(hfc_pkg::IRQ_XPR);
    chk("isr xpr me", 32'h1, 32'(v[hfc_pkg::IRQ_XPR]));
    chk("share flags", 32'h1, 32'(tx_share_flags));
    apb(1'b0, 8'h1C, 32'h0);
    chk("slverr", 32'h1, 32'(err_q));
    final_report();
  end

  // Watchdog
  initial
  begin
    repeat (60000) @(posedge mclk);
    num_errors++;
    final_report();
  end
endmodule
`default_nettype wire

// file: logic/hfc_ctrl.sv
// HDLC channel FIFO controller: receive and transmit FIFOs behind an APB slave.
// Assumes serializers on the link side that move whole bytes, flags and CRC.
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module hfc_ctrl #(
  parameter bit D_CHANNEL = 1'b1,
  parameter int RX_DEPTH  = hfc_pkg::DEPTH_D,
  parameter int TX_DEPTH  = hfc_pkg::DEPTH_D
) (
  input  wire logic               mclk,
  input  wire logic               resetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               rx_frame_start,
  input  wire logic               rx_byte_valid,
  input  wire logic [7:0]         rx_byte,
  input  wire logic               rx_frame_end,
  input  wire hfc_pkg::hfc_rx_end_t rx_end_info,
  output logic                    tx_valid,
  output logic [7:0]              tx_data,
  output logic                    tx_first,
  output logic                    tx_last,
  output logic                    tx_share_flags,
  output logic                    tx_abort,
  input  wire logic               tx_ready,
  input  wire logic               tx_closed,
  input  wire logic               tx_collision
);
  localparam int RXA = $clog2(RX_DEPTH);
  localparam int TXA = $clog2(TX_DEPTH);
  localparam logic [7:0] RX_BLK = D_CHANNEL ? hfc_pkg::RX_BLK_D : hfc_pkg::RX_BLK_B;
  localparam logic [7:0] RXD = 8'(RX_DEPTH);
  localparam logic [7:0] TXD = 8'(TX_DEPTH);

  // Depths must be powers of two the 8-bit pointers can serve
  if (RX_DEPTH < 32 || RX_DEPTH > 128 || (RX_DEPTH & (RX_DEPTH - 1)) != 0 ||
      TX_DEPTH < 64 || TX_DEPTH > 128 || (TX_DEPTH & (TX_DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("hfc_ctrl: unsupported FIFO depth");
  end

  hfc_pkg::hfc_state_t st_r;
  hfc_pkg::hfc_state_t st_nxt;
  logic [8:0]  rx_mem [RX_DEPTH];
  logic [7:0]  tx_mem [TX_DEPTH];
  logic        rx_we;
  logic [8:0]  rx_wdat;
  logic        tx_we;
  logic        acc, wr, rd;
  logic [7:0]  cmd;
  logic [7:0]  rx_free, rx_limit, rx_blen, tx_free, tx_cfree;
  logic [12:0] rx_cnt;
  logic        rx_avail, tx_write_enable_flag, underrun, rres, tx_reset_cmd;
  logic [7:0]  rx_rdata, set_irq;
  logic [8:0]  scan_ent;

  // APB decode, zero wait states
  assign acc     = psel && penable;
  assign wr      = acc && pwrite;
  assign rd      = acc && !pwrite;
  assign pready  = 1'b1;
  assign cmd     = (wr && paddr == hfc_pkg::ADDR_CMD) ? pwdata[7:0] : 8'h00;
  assign rres    = cmd[hfc_pkg::CMD_RRES];
  assign tx_reset_cmd    = cmd[hfc_pkg::CMD_TX_RESET_CMD];
  assign pslverr = acc && !(paddr == hfc_pkg::ADDR_FIFO || paddr == hfc_pkg::ADDR_CMD ||
                            paddr == hfc_pkg::ADDR_ISR  || paddr == hfc_pkg::ADDR_STAT ||
                            paddr == hfc_pkg::ADDR_EXM  || paddr == hfc_pkg::ADDR_CNTL ||
                            paddr == hfc_pkg::ADDR_CNTH);

  // Receive occupancy, read limit and length count
  assign rx_free  = RXD - (st_r.rx_wp - st_r.rx_bs);
  assign rx_limit = st_r.rx_busy ? st_r.rx_blk_end : st_r.rx_wp;
  assign rx_avail = st_r.rx_rp != rx_limit;
  assign rx_rdata = rx_avail ? rx_mem[st_r.rx_rp[RXA-1:0]][7:0] : st_r.rx_last;
  assign rx_blen  = st_r.rx_busy ? (st_r.rx_blk_end - st_r.rx_bs) : 8'h00;
  assign rx_cnt   = {1'b0, st_r.rx_flen} + {5'h00, rx_blen};
  assign scan_ent = rx_mem[st_r.rx_sp[RXA-1:0]];

  // Transmit occupancy and write enable
  assign tx_free   = TXD - (st_r.tx_wp - st_r.tx_rp);
  assign tx_cfree  = TXD - (st_r.tx_cp - st_r.tx_rp);
  assign tx_write_enable_flag       = !st_r.tx_lock && !st_r.isr[hfc_pkg::IRQ_XDU] &&
                     !st_r.isr[hfc_pkg::IRQ_XMR] && tx_free != 8'h00;
  assign underrun  = st_r.tx_infrm && st_r.tx_rp == st_r.tx_cp && tx_ready;

  // Link-side transmit outputs
  assign tx_valid       = st_r.tx_rp != st_r.tx_cp;
  assign tx_data        = tx_mem[st_r.tx_rp[TXA-1:0]];
  assign tx_first       = tx_valid && !st_r.tx_infrm;
  assign tx_last        = tx_valid && st_r.tx_fe_v && (st_r.tx_rp + 8'h01) == st_r.tx_fe;
  assign tx_share_flags = st_r.tx_share;
  assign tx_abort       = st_r.tx_abort;

  // Register read mux
  always_comb
  begin
    prdata = 32'h0000_0000;
    unique case (paddr)
      hfc_pkg::ADDR_FIFO: prdata[7:0] = rx_rdata;
      hfc_pkg::ADDR_ISR:  prdata[7:0] = st_r.isr;
      hfc_pkg::ADDR_STAT:
      begin
        prdata[hfc_pkg::STAT_TX_DATA_OVERFLOW] = st_r.tx_dov;
        prdata[hfc_pkg::STAT_XFW]  = tx_write_enable_flag;
      end
      hfc_pkg::ADDR_EXM:
      begin
        prdata[2:0]               = st_r.mode;
        prdata[hfc_pkg::EXM_TX_BLOCK_SIZE_SEL] = st_r.tx_sel;
      end
      hfc_pkg::ADDR_CNTL: prdata[7:0] = rx_cnt[7:0];
      hfc_pkg::ADDR_CNTH: prdata[7:0] = {st_r.rx_lov | rx_cnt[12], 3'h0, rx_cnt[11:8]};
      default:            prdata = 32'h0000_0000;
    endcase
  end

  // Next-state logic for both FIFOs and the register file
  always_comb
  begin
    st_nxt      = st_r;
    rx_we       = 1'b0;
    rx_wdat     = 9'h000;
    tx_we       = 1'b0;
    set_irq     = 8'h00;
    st_nxt.tx_abort = 1'b0;

    // Mode register; block select only exists on the D-channel
    if (wr && paddr == hfc_pkg::ADDR_EXM)
    begin
      st_nxt.mode   = pwdata[2:0];
      st_nxt.tx_sel = D_CHANNEL && pwdata[hfc_pkg::EXM_TX_BLOCK_SIZE_SEL];
    end

    // Receive link side
    if (rx_frame_start)
    begin
      st_nxt.rx_ovf  = 1'b0;
      st_nxt.rx_drop = rx_free <= 8'h01;
      if (rx_free <= 8'h01)
        set_irq[hfc_pkg::IRQ_RFO] = 1'b1;
    end
    else if (rx_byte_valid && !st_r.rx_drop)
    begin
      if (rx_free > 8'h01)
      begin
        rx_we          = 1'b1;
        rx_wdat        = {1'b0, rx_byte};
        st_nxt.rx_wp   = st_r.rx_wp + 8'h01;
      end
      else
        st_nxt.rx_ovf = 1'b1;
    end
    else if (rx_frame_end)
    begin
      st_nxt.rx_drop = 1'b0;
      if (!st_r.rx_drop)
      begin
        // Status byte closes the frame, one slot always kept for it
        rx_we                       = 1'b1;
        rx_wdat[8]                  = 1'b1;
        rx_wdat[hfc_pkg::ST_VFR]    = rx_end_info.valid;
        rx_wdat[hfc_pkg::ST_CRC]    = rx_end_info.crc_ok;
        rx_wdat[hfc_pkg::ST_RAB]    = rx_end_info.abort;
        rx_wdat[hfc_pkg::ST_RDO]    = st_r.rx_ovf || rx_byte_valid;
        rx_wdat[hfc_pkg::ST_TA]     = st_r.mode != hfc_pkg::MODE_TRANS0 && rx_end_info.tei;
        if (st_r.mode == hfc_pkg::MODE_NONAUTO2 || st_r.mode == hfc_pkg::MODE_TRANS1)
        begin
          rx_wdat[hfc_pkg::ST_CR]                  = rx_end_info.cr;
          rx_wdat[hfc_pkg::ST_SA+1:hfc_pkg::ST_SA] = rx_end_info.sapi;
        end
        st_nxt.rx_wp = st_r.rx_wp + 8'h01;
      end
    end

    // Scan stored bytes for a full block or a frame end
    if (!st_r.rx_busy && st_r.rx_sp != st_r.rx_wp)
    begin
      st_nxt.rx_sp = st_r.rx_sp + 8'h01;
      if (scan_ent[8] || (st_r.rx_sp - st_r.rx_bs + 8'h01) == RX_BLK)
      begin
        st_nxt.rx_busy    = 1'b1;
        st_nxt.rx_msg_end = scan_ent[8];
        st_nxt.rx_blk_end = st_r.rx_sp + 8'h01;
        set_irq[scan_ent[8] ? hfc_pkg::IRQ_RME : hfc_pkg::IRQ_RPF] = 1'b1;
      end
    end

    // Host reads advance only over valid bytes
    if (rd && paddr == hfc_pkg::ADDR_FIFO && rx_avail)
    begin
      st_nxt.rx_rp   = st_r.rx_rp + 8'h01;
      st_nxt.rx_last = rx_rdata;
    end

    // Block release frees the whole block whatever was read
    if (cmd[hfc_pkg::CMD_RMC] && st_r.rx_busy)
    begin
      st_nxt.rx_bs   = st_r.rx_blk_end;
      st_nxt.rx_rp   = st_r.rx_blk_end;
      st_nxt.rx_busy = 1'b0;
      st_nxt.rx_flen = st_r.rx_msg_end ? 12'h000 : rx_cnt[11:0];
      st_nxt.rx_lov  = !st_r.rx_msg_end && (st_r.rx_lov || rx_cnt[12]);
    end
    if (rres)
    begin
      st_nxt.rx_wp   = 8'h00;
      st_nxt.rx_bs   = 8'h00;
      st_nxt.rx_sp   = 8'h00;
      st_nxt.rx_rp   = 8'h00;
      st_nxt.rx_busy = 1'b0;
      st_nxt.rx_drop = 1'b0;
      st_nxt.rx_ovf  = 1'b0;
      st_nxt.rx_flen = 12'h000;
      st_nxt.rx_lov  = 1'b0;
      rx_we          = 1'b0;
    end

    // Host writes into the transmit FIFO
    if (wr && paddr == hfc_pkg::ADDR_FIFO && tx_write_enable_flag)
    begin
      tx_we          = 1'b1;
      st_nxt.tx_wp   = st_r.tx_wp + 8'h01;
      st_nxt.tx_wcnt = st_r.tx_wcnt + 8'h01;
      if (st_r.tx_wcnt >= st_r.tx_blk)
        st_nxt.tx_dov = 1'b1;
    end

    // Frame and message end commands commit the written data
    if (cmd[hfc_pkg::CMD_XTF] || cmd[hfc_pkg::CMD_XME])
    begin
      st_nxt.tx_cp   = st_nxt.tx_wp;
      st_nxt.tx_wcnt = 8'h00;
      st_nxt.tx_blk  = st_r.tx_sel ? hfc_pkg::TX_BLK_SMALL : hfc_pkg::TX_BLK_DEF;
      st_nxt.tx_arm  = !(cmd[hfc_pkg::CMD_XTF] && cmd[hfc_pkg::CMD_XME]);
      if (cmd[hfc_pkg::CMD_XME])
      begin
        st_nxt.tx_fe    = st_nxt.tx_wp;
        st_nxt.tx_fe_v  = 1'b1;
        st_nxt.tx_share = !cmd[hfc_pkg::CMD_XTF];
        st_nxt.tx_lock  = cmd[hfc_pkg::CMD_XTF];
      end
    end

    // Pool ready once a whole block of space is free
    if (st_r.tx_arm && !st_r.tx_lock && tx_cfree >= st_r.tx_blk)
    begin
      st_nxt.tx_arm             = 1'b0;
      set_irq[hfc_pkg::IRQ_XPR] = 1'b1;
    end

    // Byte handed to the serializer
    if (tx_valid && tx_ready)
    begin
      st_nxt.tx_rp    = st_r.tx_rp + 8'h01;
      st_nxt.tx_infrm = !tx_last;
      st_nxt.tx_fcnt  = st_r.tx_infrm ? ((st_r.tx_fcnt == hfc_pkg::FCNT_MAX) ? st_r.tx_fcnt
                                         : st_r.tx_fcnt + 8'h01) : 8'h01;
      if (!st_r.tx_infrm)
        st_nxt.tx_fs = st_r.tx_rp;
      if (tx_last)
        st_nxt.tx_fe_v = 1'b0;
    end

    // Closing flag sent ends the lock
    if (tx_closed && st_r.tx_lock && !st_r.tx_fe_v)
    begin
      st_nxt.tx_lock            = 1'b0;
      set_irq[hfc_pkg::IRQ_XPR] = 1'b1;
    end

    // Collision: retry from frame start, or ask for a repeat
    if (tx_collision && st_r.tx_infrm && D_CHANNEL)
    begin
      if (st_r.tx_fcnt >= st_r.tx_blk)
        set_irq[hfc_pkg::IRQ_XMR] = 1'b1;
      else
      begin
        st_nxt.tx_rp    = st_r.tx_fs;
        st_nxt.tx_infrm = 1'b0;
      end
    end
    else if (underrun)
      set_irq[hfc_pkg::IRQ_XDU] = 1'b1;

    // Underrun, repeat or reset empties the FIFO and aborts
    if (set_irq[hfc_pkg::IRQ_XDU] || set_irq[hfc_pkg::IRQ_XMR] || tx_reset_cmd)
    begin
      st_nxt.tx_wp    = 8'h00;
      st_nxt.tx_cp    = 8'h00;
      st_nxt.tx_rp    = 8'h00;
      st_nxt.tx_fs    = 8'h00;
      st_nxt.tx_infrm = 1'b0;
      st_nxt.tx_fe_v  = 1'b0;
      st_nxt.tx_lock  = 1'b0;
      st_nxt.tx_arm   = 1'b0;
      st_nxt.tx_abort = 1'b1;
      tx_we           = 1'b0;
    end
    if (tx_reset_cmd)
    begin
      st_nxt.tx_wcnt            = 8'h00;
      st_nxt.tx_dov             = 1'b0;
      st_nxt.tx_share           = 1'b0;
      st_nxt.tx_blk             = st_r.tx_sel ? hfc_pkg::TX_BLK_SMALL : hfc_pkg::TX_BLK_DEF;
      set_irq[hfc_pkg::IRQ_XPR] = 1'b1;
    end

    // Sticky interrupt bits, cleared by reading, new events win
    st_nxt.isr = ((rd && paddr == hfc_pkg::ADDR_ISR) ? 8'h00 : st_r.isr) | set_irq;
  end

  // State register
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      st_r <= hfc_pkg::ST_RST;
    else
      st_r <= st_nxt;
  end

  // FIFO storage, cyclic by pointer wrap
  always_ff @(posedge mclk)
  begin
    if (rx_we)
      rx_mem[st_r.rx_wp[RXA-1:0]] <= rx_wdat;
    if (tx_we)
      tx_mem[st_r.tx_wp[TXA-1:0]] <= pwdata[7:0];
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_rx_frame_lost: assert property (rx_frame_start && rx_free <= 8'h01 |=> st_r.isr[hfc_pkg::IRQ_RFO] && st_r.rx_drop)
    else $error("frame lost not flagged");
  a_rx_status_last: assert property (rx_frame_end && !rx_frame_start && !rx_byte_valid && !st_r.rx_drop && !rres
    |-> rx_we && rx_wdat[8] && rx_wdat[hfc_pkg::ST_RDO] == st_r.rx_ovf)
    else $error("status byte not stored");
  a_rx_read_hold: assert property (rd && paddr == hfc_pkg::ADDR_FIFO && !rx_avail
    |-> prdata[7:0] == st_r.rx_last ##1 st_r.rx_rp == $past(st_r.rx_rp))
    else $error("read past data moved pointer");
  a_rx_release: assert property (cmd[hfc_pkg::CMD_RMC] && st_r.rx_busy && !rres
    |=> st_r.rx_bs == $past(st_r.rx_blk_end) && st_r.rx_rp == st_r.rx_bs)
    else $error("block not released");
  a_tx_lock_write: assert property ((st_r.isr[hfc_pkg::IRQ_XDU] || st_r.isr[hfc_pkg::IRQ_XMR]) && wr &&
    paddr == hfc_pkg::ADDR_FIFO |=> $stable(st_r.tx_wp))
    else $error("write accepted while locked");
  a_tx_reset_xpr: assert property (tx_reset_cmd |=> st_r.isr[hfc_pkg::IRQ_XPR] && tx_abort && st_r.tx_wp == 8'h00)
    else $error("transmitter reset incomplete");
  a_tx_underrun: assert property (underrun && !tx_collision && !tx_reset_cmd
    |=> st_r.isr[hfc_pkg::IRQ_XDU] && tx_abort ##1 !tx_abort)
    else $error("underrun not handled");
  a_tx_overflow: assert property (wr && paddr == hfc_pkg::ADDR_FIFO && tx_write_enable_flag && st_r.tx_wcnt >= st_r.tx_blk && !tx_reset_cmd
    |=> st_r.tx_dov)
    else $error("overflow status missing");
  a_tx_lock_pr: assert property (st_r.tx_lock |-> !tx_write_enable_flag && !set_irq[hfc_pkg::IRQ_XPR] || tx_closed || tx_reset_cmd)
    else $error("pool ready during lock");

  c_rx_msg_end: cover property (set_irq[hfc_pkg::IRQ_RME] ##[1:200] cmd[hfc_pkg::CMD_RMC]);
  c_tx_frame_pr: cover property (cmd[hfc_pkg::CMD_XTF] ##[1:10] set_irq[hfc_pkg::IRQ_XPR]);
  c_tx_repeat: cover property (set_irq[hfc_pkg::IRQ_XMR]);
  c_tx_closed: cover property (st_r.tx_lock ##[1:500] tx_closed);
endmodule
`default_nettype wire

// file: logic/hfc_pkg.sv
// HDLC FIFO host control: register map, field positions, reset values.
// Assumes APB with 32-bit data; registers sit in the low byte of a word.
`default_nettype none
package hfc_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_FIFO = 8'h00;  // Read rx_fifo, write tx_fifo
  localparam logic [7:0] ADDR_CMD  = 8'h04;  // channel_command_reg
  localparam logic [7:0] ADDR_ISR  = 8'h08;  // channel_irq_status, clear on read
  localparam logic [7:0] ADDR_STAT = 8'h0C;  // channel_status_reg
  localparam logic [7:0] ADDR_EXM  = 8'h10;  // extended_mode_reg
  localparam logic [7:0] ADDR_CNTL = 8'h14;  // rx_count_low
  localparam logic [7:0] ADDR_CNTH = 8'h18;  // rx_count_high
  // Command bits
  localparam int CMD_RMC  = 0;
  localparam int CMD_XTF  = 1;
  localparam int CMD_XME  = 2;
  localparam int CMD_TX_RESET_CMD = 3;
  localparam int CMD_RRES = 4;
  // Interrupt status bits
  localparam int IRQ_RPF = 7;
  localparam int IRQ_RME = 6;
  localparam int IRQ_RFO = 5;
  localparam int IRQ_XPR = 4;
  localparam int IRQ_XDU = 3;
  localparam int IRQ_XMR = 2;
  // Status register bits
  localparam int STAT_TX_DATA_OVERFLOW = 6;
  localparam int STAT_XFW  = 5;
  // Mode register fields
  localparam int EXM_TX_BLOCK_SIZE_SEL = 5;
  localparam logic [2:0] MODE_NONAUTO2 = 3'h3;
  localparam logic [2:0] MODE_TRANS0   = 3'h6;
  localparam logic [2:0] MODE_TRANS1   = 3'h7;
  // Receive status byte fields
  localparam int ST_VFR = 7;
  localparam int ST_RDO = 6;
  localparam int ST_CRC = 5;
  localparam int ST_RAB = 4;
  localparam int ST_SA  = 2;  // Two bits, 3:2
  localparam int ST_CR  = 1;
  localparam int ST_TA  = 0;
  // Block sizes and depths
  localparam logic [7:0] TX_BLK_DEF   = 8'h20;
  localparam logic [7:0] TX_BLK_SMALL = 8'h10;
  localparam logic [7:0] RX_BLK_D     = 8'h20;
  localparam logic [7:0] RX_BLK_B     = 8'h10;
  localparam int DEPTH_D = 64;
  localparam int DEPTH_B = 128;
  localparam logic [7:0] FCNT_MAX = 8'hFF;

  // Frame end information from the receive serializer
  typedef struct packed {
    logic       crc_ok;
    logic       valid;
    logic       abort;
    logic [1:0] sapi;
    logic       cr;
    logic       tei;
  } hfc_rx_end_t;

  // Whole controller state
  typedef struct packed {
    logic [7:0]  rx_wp, rx_bs, rx_sp, rx_rp, rx_blk_end, rx_last;
    logic        rx_busy, rx_msg_end, rx_drop, rx_ovf, rx_lov;
    logic [11:0] rx_flen;
    logic [7:0]  tx_wp, tx_cp, tx_rp, tx_fs, tx_fe, tx_fcnt, tx_wcnt, tx_blk;
    logic        tx_fe_v, tx_lock, tx_infrm, tx_sel, tx_arm, tx_dov, tx_share, tx_abort;
    logic [7:0]  isr;
    logic [2:0]  mode;
  } hfc_state_t;

  localparam hfc_state_t ST_RST = '{tx_blk: TX_BLK_DEF, default: '0};
endpackage
`default_nettype wire
